// File: design/lsa_pkg.sv
package lsa_pkg;
  // ==========================================================
  // register offsets (plain port, 12-bit address)
  localparam logic [11:0] ADDR_LIN_CONTROL  = 12'hf43;
  localparam logic [11:0] ADDR_NODE_ADDRESS = 12'hf45;
  localparam logic [11:0] ADDR_MODE_CONTROL = 12'hf41;
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'hf50;
  localparam logic [11:0] ADDR_IRQ_MASK     = 12'hf51;
  localparam logic [11:0] ADDR_BAUD_HIGH    = 12'hf46;
  localparam logic [11:0] ADDR_BAUD_LOW     = 12'hf47;
  localparam logic [11:0] ADDR_BREAK_CMD    = 12'hf52;
  // ==========================================================
  // lin_control fields
  localparam int LC_MASTER_BIT = 7;
  localparam int LC_SLAVE_BIT  = 6;
  localparam int LC_STATE_LO   = 2;
  localparam int LC_BREAK_LO   = 0;
  // mode control fields
  localparam int MC_MODE_LO    = 3;
  localparam int MC_MN_EN_BIT  = 2;
  localparam int MC_PARITY_BIT = 1;
  // irq bits
  localparam int IRQ_RX_BIT    = 0;
  localparam int IRQ_BRK_BIT   = 1;
  localparam int IRQ_STATE_BIT = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_LIN_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_NODE_ADDRESS = 8'h00;
  localparam logic [7:0]  RST_MODE_CONTROL = 8'h00;
  localparam logic [15:0] RST_BAUD         = 16'hffff;
  localparam logic [4:0]  BREAK_BASE_BITS  = 5'h0d;
  typedef enum logic [1:0] {
    LSA_SLEEP    = 2'b00,
    LSA_WAIT_BRK = 2'b01,
    LSA_AUTOBAUD = 2'b10,
    LSA_ACTIVE   = 2'b11
  } lsa_state_type;
endpackage : lsa_pkg

// File: design/lsa_break_gen.sv
module lsa_break_gen
  import lsa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [1:0]  length_sel,
  input  wire logic [15:0] baud_div,
  output logic             busy,
  output logic             done
);
  logic [15:0] tick_cnt;
  logic [4:0]  bit_cnt;
  logic [15:0] next_tick_cnt;
  logic [4:0]  next_bit_cnt;
  logic        next_busy;
  logic        next_done;
  // ==========================================================
  // bit-period counting
  always_comb begin
    next_tick_cnt = tick_cnt;
    next_bit_cnt  = bit_cnt;
    next_busy     = busy;
    next_done     = 1'b0;
    if (!busy) begin
      if (start) begin
        next_busy     = 1'b1;
        next_tick_cnt = 16'h0000;
        next_bit_cnt  = BREAK_BASE_BITS + {3'h0, length_sel};
      end
    end else if (tick_cnt + 16'h0001 >= baud_div) begin
      next_tick_cnt = 16'h0000;
      next_bit_cnt  = bit_cnt - 5'h01;
      if (bit_cnt == 5'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end else begin
      next_tick_cnt = tick_cnt + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
      bit_cnt  <= 5'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      bit_cnt  <= next_bit_cnt;
      busy     <= next_busy;
      done     <= next_done;
    end
  end
endmodule : lsa_break_gen

// File: design/lsa_lin_core.sv
// Operation
// - state codes: sleep 00, wait 01, autobaud 10, active 11
// - software write forces state any time
// - slave hardware cycles wait, autobaud, active
// - wait and autobaud only valid for slave
// - master stays active until software writes sleep
// - break length select gives 13 to 16 bits
// - address compare mode compares every address byte
// - in compare mode only a matching address and the data bytes after it raise rx interrupt, data-available; otherwise every byte does
// - role active only with other selects clear
module lsa_lin_core
  import lsa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        break_seen,
  input  wire logic        autobaud_done,
  input  wire logic        frame_done,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_is_address,
  output logic             receive_data_available,
  output logic             lin_tx_dominant,
  output logic             irq
);
  logic [7:0]    lin_control;
  logic [7:0]    node_address_compare;
  logic [7:0]    mode_control;
  logic [15:0]   baud_div;
  logic [2:0]    irq_status;
  logic [2:0]    irq_mask;
  logic          addr_matched;
  logic          break_start;
  logic          brk_busy;
  logic          brk_done;
  logic [7:0]    next_lin_control;
  logic [7:0]    next_node_address_compare;
  logic [7:0]    next_mode_control;
  logic [15:0]   next_baud_div;
  logic [2:0]    next_irq_status;
  logic [2:0]    next_irq_mask;
  logic          next_addr_matched;
  logic          next_break_start;
  logic          next_rda;
  logic          next_irq;
  logic          next_lin_tx_dominant;
  logic [7:0]    next_reg_rdata;
  logic          master_role_select;
  logic          slave_role_select;
  logic [1:0]    multinode_mode_field;
  logic          master_active;
  logic          slave_active;
  lsa_state_type lin_fsm_state;
  lsa_state_type next_fsm;
  logic [2:0]    events;
  logic          rx_accept;
  logic          state_wr;
  // ==========================================================
  // role decode
  always_comb begin
    master_role_select   = lin_control[LC_MASTER_BIT];
    slave_role_select    = lin_control[LC_SLAVE_BIT];
    multinode_mode_field = mode_control[MC_MODE_LO +: 2];
    lin_fsm_state        = lsa_state_type'(lin_control[LC_STATE_LO +: 2]);
    master_active = master_role_select && !slave_role_select
                    && !mode_control[MC_MN_EN_BIT] && !mode_control[MC_PARITY_BIT];
    slave_active  = slave_role_select && !master_role_select
                    && !mode_control[MC_MN_EN_BIT] && !mode_control[MC_PARITY_BIT];
    state_wr      = reg_wr && (reg_addr == ADDR_LIN_CONTROL);
  end
  // ==========================================================
  // lin state machine
  always_comb begin
    next_fsm = lin_fsm_state;
    if (slave_active) begin
      case (lin_fsm_state)
        LSA_SLEEP:    next_fsm = LSA_SLEEP;
        LSA_WAIT_BRK: if (break_seen) next_fsm = LSA_AUTOBAUD;
        LSA_AUTOBAUD: if (autobaud_done) next_fsm = LSA_ACTIVE;
        LSA_ACTIVE:   if (frame_done) next_fsm = LSA_WAIT_BRK;
        default:      next_fsm = LSA_SLEEP;
      endcase
    end else if (master_active) begin
      case (lin_fsm_state)
        LSA_SLEEP:  next_fsm = LSA_SLEEP;
        LSA_ACTIVE: next_fsm = LSA_ACTIVE;
        default:    next_fsm = lin_fsm_state;
      endcase
    end
  end
  // ==========================================================
  // address compare
  always_comb begin
    rx_accept         = 1'b0;
    next_addr_matched = addr_matched;
    if (rx_byte_valid) begin
      if (multinode_mode_field[1]) begin
        if (rx_is_address) begin
          next_addr_matched = (rx_byte == node_address_compare);
          rx_accept         = next_addr_matched;
        end else begin
          rx_accept = addr_matched;
        end
      end else begin
        rx_accept = 1'b1;
      end
    end
  end
  // ==========================================================
  // registers and interrupts
  always_comb begin
    next_lin_control          = lin_control;
    next_node_address_compare = node_address_compare;
    next_mode_control         = mode_control;
    next_baud_div             = baud_div;
    next_irq_mask             = irq_mask;
    next_break_start          = 1'b0;
    next_reg_rdata            = 8'h00;
    next_lin_control[LC_STATE_LO +: 2] = next_fsm;
    events = 3'h0;
    events[IRQ_RX_BIT]    = rx_accept;
    events[IRQ_BRK_BIT]   = brk_done;
    events[IRQ_STATE_BIT] = (next_fsm != lin_fsm_state) && !state_wr;
    next_irq_status = irq_status;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_LIN_CONTROL:  next_lin_control = reg_wdata;
        ADDR_NODE_ADDRESS: next_node_address_compare = reg_wdata;
        ADDR_MODE_CONTROL: next_mode_control = reg_wdata;
        ADDR_BAUD_HIGH:    next_baud_div[15:8] = reg_wdata;
        ADDR_BAUD_LOW:     next_baud_div[7:0] = reg_wdata;
        ADDR_IRQ_STATUS:   next_irq_status = irq_status & ~reg_wdata[2:0];
        ADDR_IRQ_MASK:     next_irq_mask = reg_wdata[2:0];
        ADDR_BREAK_CMD:    next_break_start = reg_wdata[0] && master_active
                                              && (lin_fsm_state == LSA_ACTIVE);
        default:           next_irq_mask = irq_mask;
      endcase
    end
    next_irq_status = next_irq_status | events;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_LIN_CONTROL:  next_reg_rdata = lin_control;
        ADDR_NODE_ADDRESS: next_reg_rdata = node_address_compare;
        ADDR_MODE_CONTROL: next_reg_rdata = mode_control;
        ADDR_BAUD_HIGH:    next_reg_rdata = baud_div[15:8];
        ADDR_BAUD_LOW:     next_reg_rdata = baud_div[7:0];
        ADDR_IRQ_STATUS:   next_reg_rdata = {5'h00, irq_status};
        ADDR_IRQ_MASK:     next_reg_rdata = {5'h00, irq_mask};
        ADDR_BREAK_CMD:    next_reg_rdata = {7'h00, brk_busy};
        default:           next_reg_rdata = 8'h00;
      endcase
    end
    next_rda             = rx_accept;
    next_irq             = |(next_irq_status & next_irq_mask);
    next_lin_tx_dominant = brk_busy;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lin_control            <= RST_LIN_CONTROL;
      node_address_compare   <= RST_NODE_ADDRESS;
      mode_control           <= RST_MODE_CONTROL;
      baud_div               <= RST_BAUD;
      irq_status             <= 3'h0;
      irq_mask               <= 3'h0;
      addr_matched           <= 1'b0;
      break_start            <= 1'b0;
      reg_rdata              <= 8'h00;
      receive_data_available <= 1'b0;
      irq                    <= 1'b0;
      lin_tx_dominant        <= 1'b0;
    end else begin
      lin_control            <= next_lin_control;
      node_address_compare   <= next_node_address_compare;
      mode_control           <= next_mode_control;
      baud_div               <= next_baud_div;
      irq_status             <= next_irq_status;
      irq_mask               <= next_irq_mask;
      addr_matched           <= next_addr_matched;
      break_start            <= next_break_start;
      reg_rdata              <= next_reg_rdata;
      receive_data_available <= next_rda;
      irq                    <= next_irq;
      lin_tx_dominant        <= next_lin_tx_dominant;
    end
  end
  // ==========================================================
  // break generator
  lsa_break_gen u_break (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .start      (break_start),
    .length_sel (lin_control[LC_BREAK_LO +: 2]),
    .baud_div   (baud_div),
    .busy       (brk_busy),
    .done       (brk_done)
  );
endmodule : lsa_lin_core

// File: verif/lsa_properties.sv
// ====================================
// port checks
module lsa_checker
  import lsa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        rx_byte_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_is_address,
  input wire logic        receive_data_available,
  input wire logic        lin_tx_dominant,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] node;
  logic [7:0] mode;
  logic [7:0] mask;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      node <= 8'h00;
      mode <= 8'h00;
      mask <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_NODE_ADDRESS) node <= reg_wdata;
      if (reg_addr == ADDR_MODE_CONTROL) mode <= reg_wdata;
      if (reg_addr == ADDR_IRQ_MASK) mask <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence addr_in;
    rx_byte_valid && rx_is_address && mode[MC_MODE_LO+1];
  endsequence
  sequence brk_run;
    $rose(lin_tx_dominant) ##0 lin_tx_dominant[*8];
  endsequence
  quiet_reset_a: assert property (
    $past(sys_rst) |-> !receive_data_available && !lin_tx_dominant && !irq) else $error("busy after reset");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data without read");
  node_read_a: assert property (
    reg_rd && reg_addr == ADDR_NODE_ADDRESS |=> reg_rdata == node) else $error("node address readback");
  brk_start_a: assert property (
    $rose(lin_tx_dominant) |-> $past(reg_wr && reg_addr == ADDR_BREAK_CMD, 3)) else $error("break without command");
  brk_hold_a: assert property (
    $rose(lin_tx_dominant) |-> brk_run) else $error("break too short");
  rda_cause_a: assert property (
    receive_data_available |-> $past(rx_byte_valid)) else $error("data available without byte");
  addr_hit_a: assert property (
    addr_in ##0 rx_byte == node |=> receive_data_available) else $error("matching address dropped");
  addr_miss_a: assert property (
    addr_in ##0 rx_byte != node |=> !receive_data_available) else $error("foreign address accepted");
  irq_mask_a: assert property (
    (mask == 8'h00)[*2] |-> !irq) else $error("masked interrupt");
  irq_rx_a: assert property (
    receive_data_available && mask[IRQ_RX_BIT] |-> ##[0:2] irq) else $error("receive interrupt missing");
endmodule : lsa_checker

bind lsa_lin_core lsa_checker u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid),
  .rx_byte(rx_byte), .rx_is_address(rx_is_address), .receive_data_available(receive_data_available),
  .lin_tx_dominant(lin_tx_dominant), .irq(irq));

// File: verif/lsa_bus_node.sv
// ====================================
// far bus node and receive path
module lsa_bus_node (
  input  wire logic  ref_clk,
  output logic       break_seen,
  output logic       autobaud_done,
  output logic       frame_done,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic       rx_is_address
);
  timeunit 1ns;
  timeprecision 1ps;
  int         pseed = 62363;
  logic [7:0] held;
  logic [7:0] noise;
  initial begin
    {break_seen, autobaud_done, frame_done, rx_byte_valid, rx_is_address} = 5'h00;
    held = 8'h00;
    noise = 8'h00;
  end
  // idle data lines carry noise
  always @(posedge ref_clk) noise <= 8'($random(pseed));
  assign rx_byte = rx_byte_valid ? held : noise;
  // event pulses: 0 break, 1 autobaud, 2 frame
  task ev(input int k, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    break_seen <= (k == 0);
    autobaud_done <= (k == 1);
    frame_done <= (k == 2);
    @(posedge ref_clk);
    {break_seen, autobaud_done, frame_done} <= 3'h0;
  endtask : ev
  task rx(input logic [7:0] b, input logic a);
    @(posedge ref_clk);
    held <= b;
    rx_is_address <= a;
    rx_byte_valid <= 1'b1;
    @(posedge ref_clk);
    rx_byte_valid <= 1'b0;
    rx_is_address <= ~a;
  endtask : rx
endmodule : lsa_bus_node

// File: verif/lin_state_and_address_match_bench.sv
// ====================================
// bench top
module lin_state_and_address_match_bench
  import lsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, rx_byte_valid, rx_is_address;
  logic        break_seen, autobaud_done, frame_done, receive_data_available, lin_tx_dominant, irq;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_byte, v, a;
  int          error_cnt, comparisons, seed, st, n, k;
  lsa_lin_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .break_seen(break_seen),
    .autobaud_done(autobaud_done), .frame_done(frame_done), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_is_address(rx_is_address), .receive_data_available(receive_data_available),
    .lin_tx_dominant(lin_tx_dominant), .irq(irq));
  lsa_bus_node u_node (.ref_clk(ref_clk), .break_seen(break_seen), .autobaud_done(autobaud_done),
    .frame_done(frame_done), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_is_address(rx_is_address));
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] ad);
    @(posedge ref_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // break command, then count dominant cycles
  task brk(input int len);
    wr(ADDR_BREAK_CMD, 8'h01);
    n = 0;
    repeat (80) begin
      @(posedge ref_clk);
      #1 n += int'(lin_tx_dominant);
    end
    chk(8'(n), 8'(len));
  endtask : brk
  // slave sequence model
  function int adv(int s, int e);
    if (e == 0 && s == 1) return 2;
    if (e == 1 && s == 2) return 3;
    if (e == 2 && s == 3) return 1;
    return s;
  endfunction : adv
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
  initial begin
    seed = 62363;
    {error_cnt, comparisons} = 0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h0;
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_LIN_CONTROL);
    chk(v, RST_LIN_CONTROL);
    rd(12'h000);
    chk(v, 8'h00);
    repeat (3) begin
      a = 8'($random(seed));
      wr(ADDR_NODE_ADDRESS, a);
      rd(ADDR_NODE_ADDRESS);
      chk(v, a);
    end
    st = 1;
    wr(ADDR_LIN_CONTROL, 8'h44);
    for (k = 0; k < 6; k++) begin
      u_node.ev(k % 3, k);
      st = adv(st, k % 3);
      rd(ADDR_LIN_CONTROL);
      chk(v, 8'(8'h40 | (st << 2)));
    end
    wr(ADDR_LIN_CONTROL, 8'h48);
    rd(ADDR_LIN_CONTROL);
    chk(v, 8'h48);
    fork
      u_node.ev(1, 0);
      wr(ADDR_LIN_CONTROL, 8'h44);
    join
    rd(ADDR_LIN_CONTROL);
    chk(v, 8'h44);
    wr(ADDR_LIN_CONTROL, 8'h40);
    u_node.ev(0, 0);
    rd(ADDR_LIN_CONTROL);
    chk(v, 8'h40);
    wr(ADDR_BAUD_HIGH, 8'h00);
    wr(ADDR_BAUD_LOW, 8'h03);
    wr(ADDR_LIN_CONTROL, 8'h84);
    for (k = 0; k < 3; k++) u_node.ev(k, 0);
    rd(ADDR_LIN_CONTROL);
    chk(v, 8'h84);
    brk(0);
    wr(ADDR_LIN_CONTROL, 8'h8c);
    for (k = 0; k < 3; k++) u_node.ev(k, 0);
    rd(ADDR_LIN_CONTROL);
    chk(v, 8'h8c);
    for (k = 0; k < 4; k++) begin
      wr(ADDR_LIN_CONTROL, 8'(8'h8c + k));
      brk((13 + k) * 3);
    end
    rd(ADDR_IRQ_STATUS);
    chk(v, 8'h06);
    wr(ADDR_LIN_CONTROL, 8'hcc);
    brk(0);
    wr(ADDR_LIN_CONTROL, 8'h8c);
    wr(ADDR_MODE_CONTROL, 8'h02);
    brk(0);
    wr(ADDR_IRQ_STATUS, 8'hff);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_MODE_CONTROL, 8'h10);
    for (k = 0; k < 4; k++) begin
      u_node.rx(k[1] ? a ^ 8'h01 : a, !k[0]);
      #1 chk(8'(receive_data_available), 8'(k < 2));
    end
    repeat (2) @(posedge ref_clk);
    #1 chk(8'(irq), 8'h01);
    rd(ADDR_IRQ_STATUS);
    chk(v, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk(8'(irq), 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_MODE_CONTROL, 8'h00);
    u_node.rx(a ^ 8'h01, 1'b1);
    #1 chk(8'(receive_data_available), 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk(8'(irq), 8'h00);
    end_sim();
  end
endmodule : lin_state_and_address_match_bench
